/* File: logic/wcsr_pkg.sv */
// Purpose: Shared constants for the watchdog control and status register block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices are kept; byte address is four times the index
package wcsr_pkg;
   // ----------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------
   localparam logic [7:0] IDX_CONTROL = 8'h00;
   localparam logic [7:0] IDX_STATUS  = 8'h01;
   localparam logic [7:0] IDX_COMMAND = 8'h02;
   localparam logic [7:0] IDX_UNLOCK  = 8'h03;
   localparam int         ADDR_W      = 4;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = ADDR_W'(IDX_CONTROL * 4);
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = ADDR_W'(IDX_STATUS * 4);
   localparam logic [ADDR_W-1:0] ADDR_COMMAND = ADDR_W'(IDX_COMMAND * 4);
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK  = ADDR_W'(IDX_UNLOCK * 4);

   // ----------------------------------------
   // Field layout and reset values
   // ----------------------------------------
   localparam int         CLOSED_HI    = 7;
   localparam int         CLOSED_LO    = 4;
   localparam int         OPEN_HI      = 3;
   localparam int         OPEN_LO      = 0;
   localparam int         LOCK_BIT     = 7;
   localparam int         BUSY_BIT     = 0;
   localparam int         RESTART_BIT  = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [3:0] CODE_OFF     = 4'h0;
   localparam logic [3:0] CODE_MAX     = 4'hb;
   localparam logic [3:0] CODE_SHIFT   = 4'h2;
   // Key value is arbitrary
   localparam logic [7:0] UNLOCK_KEY   = 8'h9c;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int          CLK_MHZ         = 50;
   localparam int          UNLOCK_NS       = 320;
   localparam logic [4:0]  UNLOCK_CYCLES   = 5'((UNLOCK_NS * CLK_MHZ + 999) / 1000);
   localparam logic [1:0]  SYNC_TICKS      = 2'h2;
   localparam int          CNT_W           = 14;
   localparam logic [CNT_W-1:0] CNT_ONE    = 14'h0001;

   typedef enum logic [2:0]
   {
      WCSR_OFF    = 3'b001,
      WCSR_CLOSED = 3'b010,
      WCSR_OPEN   = 3'b100
   } wcsr_state_t;
endpackage

/* File: logic/wcsr_top.sv */
// Purpose: Watchdog control/status registers with timeout and window checking
// Assumes: Watchdog oscillator is a slow pin, sampled as an ordinary input
// Notes:   Zero-wait APB slave; unmapped addresses answer with pslverr
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps

module wcsr_top
(
   input  wire logic                       clock,
   input  wire logic                       rstn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [wcsr_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       wdt_osc_clk,
   input  wire logic                       debug_mode,
   input  wire logic [7:0]                 boot_watchdog_setting,
   output logic                            system_reset_req,
   output logic                            unlock_open
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [1:0] osc_sync_reg;
   logic       osc_prev_reg;
   logic [1:0] dbg_sync_reg;
   logic       tick;
   logic       debug_s;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         osc_sync_reg <= 2'h0;
         osc_prev_reg <= 1'b0;
         dbg_sync_reg <= 2'h0;
      end
      else
      begin
         osc_sync_reg <= {osc_sync_reg[0], wdt_osc_clk};
         osc_prev_reg <= osc_sync_reg[1];
         dbg_sync_reg <= {dbg_sync_reg[0], debug_mode};
      end
   end

   assign tick    = osc_sync_reg[1] & ~osc_prev_reg;
   assign debug_s = dbg_sync_reg[1];

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   logic setup;
   logic access;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_cmd;
   logic hit_key;
   logic mapped;
   logic wr;

   assign setup    = psel & ~penable;
   assign access   = psel & penable;
   assign hit_ctrl = (paddr == wcsr_pkg::ADDR_CONTROL);
   assign hit_stat = (paddr == wcsr_pkg::ADDR_STATUS);
   assign hit_cmd  = (paddr == wcsr_pkg::ADDR_COMMAND);
   assign hit_key  = (paddr == wcsr_pkg::ADDR_UNLOCK);
   assign mapped   = hit_ctrl | hit_stat | hit_cmd | hit_key;
   assign wr       = access & pwrite & mapped;
   assign pready   = 1'b1;
   assign pslverr  = access & ~mapped;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0]  ctrl_reg;
   logic [7:0]  ctrl_active_reg;
   logic        lock_reg;
   logic        busy_reg;
   logic [1:0]  busy_cnt_reg;
   logic [4:0]  key_cnt_reg;
   logic        loaded_reg;
   logic        key_ok;
   logic        ctrl_we;
   logic        lock_set;
   logic        lock_clr;
   logic        key_write;
   logic [7:0]  status_val;

   assign key_write  = wr & hit_key & (pwdata[7:0] == wcsr_pkg::UNLOCK_KEY);
   assign key_ok     = (key_cnt_reg != 5'h00);
   assign unlock_open = key_ok;
   assign ctrl_we    = wr & hit_ctrl & key_ok & ~lock_reg;
   assign lock_set   = wr & hit_stat & key_ok & pwdata[wcsr_pkg::LOCK_BIT];
   assign lock_clr   = wr & hit_stat & key_ok & ~pwdata[wcsr_pkg::LOCK_BIT] & debug_s;
   assign status_val = {lock_reg, 6'h00, busy_reg};

   // Unlock window: opens on key, closes after one protected write or timeout
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         key_cnt_reg <= 5'h00;
      else if (key_write)
         key_cnt_reg <= wcsr_pkg::UNLOCK_CYCLES;
      else if (wr & (hit_ctrl | hit_stat))
         key_cnt_reg <= 5'h00;
      else if (key_ok)
         key_cnt_reg <= key_cnt_reg - 5'h01;
   end

   // Boot load is one clocked step after release, never under reset
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         loaded_reg <= 1'b0;
         ctrl_reg   <= 8'h00;
         lock_reg   <= wcsr_pkg::STATUS_RESET[wcsr_pkg::LOCK_BIT];
      end
      else if (!loaded_reg)
      begin
         loaded_reg <= 1'b1;
         ctrl_reg   <= boot_watchdog_setting;
         lock_reg   <= (boot_watchdog_setting[wcsr_pkg::OPEN_HI:wcsr_pkg::OPEN_LO]
                        != wcsr_pkg::CODE_OFF);
      end
      else
      begin
         if (ctrl_we)
            ctrl_reg <= pwdata[7:0];
         if (lock_set)
            lock_reg <= 1'b1;
         else if (lock_clr)
            lock_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Crossing into the watchdog tick domain
   // ----------------------------------------
   // Busy counts whole ticks so the new value lands between two counts
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         busy_reg        <= wcsr_pkg::STATUS_RESET[wcsr_pkg::BUSY_BIT];
         busy_cnt_reg    <= 2'h0;
         ctrl_active_reg <= 8'h00;
      end
      else if (ctrl_we | ~loaded_reg)
      begin
         // Busy raised on write, set wins
         busy_reg     <= 1'b1;
         busy_cnt_reg <= 2'h0;
      end
      else if (busy_reg & tick)
      begin
         if (busy_cnt_reg == wcsr_pkg::SYNC_TICKS - 2'h1)
         begin
            busy_reg        <= 1'b0;
            ctrl_active_reg <= ctrl_reg;
         end
         busy_cnt_reg <= busy_cnt_reg + 2'h1;
      end
   end

   // ----------------------------------------
   // Restart command crossing
   // ----------------------------------------
   logic       rst_pend_reg;
   logic [1:0] rst_cnt_reg;
   logic       restart_apply;
   logic       restart_cmd;

   assign restart_cmd   = wr & hit_cmd & pwdata[wcsr_pkg::RESTART_BIT];
   assign restart_apply = rst_pend_reg & tick & (rst_cnt_reg == wcsr_pkg::SYNC_TICKS - 2'h1);

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_pend_reg <= 1'b0;
         rst_cnt_reg  <= 2'h0;
      end
      else if (restart_cmd & ~rst_pend_reg)
      begin
         rst_pend_reg <= 1'b1;
         rst_cnt_reg  <= 2'h0;
      end
      else if (rst_pend_reg & tick)
      begin
         rst_pend_reg <= ~restart_apply;
         rst_cnt_reg  <= rst_cnt_reg + 2'h1;
      end
   end

   // ----------------------------------------
   // Timeout and window engine
   // ----------------------------------------
   // Reserved codes fall to the longest period; behaviour is undefined anyway
   function automatic logic [wcsr_pkg::CNT_W-1:0] ticks_of(input logic [3:0] code);
      logic [3:0] c;
      c = (code > wcsr_pkg::CODE_MAX) ? wcsr_pkg::CODE_MAX : code;
      ticks_of = wcsr_pkg::CNT_ONE << (c + wcsr_pkg::CODE_SHIFT);
   endfunction

   wcsr_pkg::wcsr_state_t    state_reg;
   wcsr_pkg::wcsr_state_t    state_next;
   logic [wcsr_pkg::CNT_W-1:0] cnt_reg;
   logic [wcsr_pkg::CNT_W-1:0] limit;
   logic [3:0]  win_code;
   logic [3:0]  per_code;
   logic        enabled;
   logic        expire;
   logic        fault;
   logic        restart_cnt;

   assign win_code = ctrl_active_reg[wcsr_pkg::CLOSED_HI:wcsr_pkg::CLOSED_LO];
   assign per_code = ctrl_active_reg[wcsr_pkg::OPEN_HI:wcsr_pkg::OPEN_LO];
   assign enabled  = (per_code != wcsr_pkg::CODE_OFF);
   assign limit    = (state_reg == wcsr_pkg::WCSR_CLOSED) ? ticks_of(win_code)
                                                          : ticks_of(per_code);
   assign expire   = tick & (cnt_reg == limit - wcsr_pkg::CNT_ONE);
   assign fault    = ((state_reg == wcsr_pkg::WCSR_OPEN) & expire & ~restart_apply)
                   | ((state_reg == wcsr_pkg::WCSR_CLOSED) & restart_apply);

   always_comb
   begin
      state_next  = state_reg;
      restart_cnt = 1'b0;
      case (state_reg)
         wcsr_pkg::WCSR_OFF:
         begin
            if (enabled)
            begin
               state_next  = wcsr_pkg::WCSR_OPEN;
               restart_cnt = 1'b1;
            end
         end
         wcsr_pkg::WCSR_OPEN:
         begin
            restart_cnt = restart_apply | expire;
            // Closed window only after a restart
            if (restart_apply & (win_code != wcsr_pkg::CODE_OFF))
               state_next = wcsr_pkg::WCSR_CLOSED;
         end
         wcsr_pkg::WCSR_CLOSED:
         begin
            restart_cnt = restart_apply | expire;
            if (restart_apply | expire)
               state_next = wcsr_pkg::WCSR_OPEN;
         end
         default:
         begin
            state_next  = wcsr_pkg::WCSR_OFF;
            restart_cnt = 1'b1;
         end
      endcase
      // Debug halt clears the count and holds the engine in WCSR_OFF
      if (!enabled | debug_s)
      begin
         state_next  = wcsr_pkg::WCSR_OFF;
         restart_cnt = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg        <= wcsr_pkg::WCSR_OFF;
         cnt_reg          <= '0;
         system_reset_req <= 1'b0;
      end
      else
      begin
         state_reg        <= state_next;
         if (restart_cnt)
            cnt_reg <= '0;
         else if (tick)
            cnt_reg <= cnt_reg + wcsr_pkg::CNT_ONE;
         system_reset_req <= fault & enabled & ~debug_s;
      end
   end

   // ----------------------------------------
   // Read data, captured in the setup cycle
   // ----------------------------------------
   logic [7:0] rd_mux;

   assign rd_mux = hit_ctrl ? ctrl_reg :
                   hit_stat ? status_val : 8'h00;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         prdata <= 32'h0000_0000;
      else if (setup)
         prdata <= {24'h00_0000, rd_mux};
   end
endmodule // wcsr_top

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the watchdog register block
// Assumes: Oscillator ticks every ten system clocks to keep runs short
// Notes:   Reads are checked from a queue by a separate monitor
`timescale 1ns/10ps
module tb_top;
   logic                        clock;
   logic                        rstn;
   logic                        psel;
   logic                        penable;
   logic                        pwrite;
   logic [wcsr_pkg::ADDR_W-1:0] paddr;
   logic [31:0]                 pwdata;
   logic [31:0]                 prdata;
   logic                        pready;
   logic                        pslverr;
   logic                        wdt_osc_clk;
   logic                        debug_mode;
   logic [7:0]                  boot_watchdog_setting;
   logic                        system_reset_req;
   logic                        unlock_open;
   logic [7:0]                  exp_q[$];
   logic [31:0]                 seed;
   logic [2:0]                  osc_cnt;
   int                          failures;
   int                          check_count;
   int                          cycles;
   int                          pulses;
   int                          n;
   int                          base;

   wcsr_top u_dut (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .wdt_osc_clk, .debug_mode, .boot_watchdog_setting, .system_reset_req,
      .unlock_open);

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      cmp({31'h0, pslverr}, {31'h0, e});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 8'h00, 1'b0);
   endtask

   task automatic unl;
      wr(wcsr_pkg::ADDR_UNLOCK, wcsr_pkg::UNLOCK_KEY);
   endtask

   task automatic pulse(input int lim);
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (system_reset_req !== 1'b1 && n < lim);
      cmp({31'h0, system_reset_req}, 32'h1);
   endtask

   // ----------------------------------------
   // Clock, oscillator, monitor, timeout
   // ----------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Free-running slow tick, phase unrelated to bus traffic
   always @(posedge clock)
   begin
      osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
      if (osc_cnt == 3'h4)
         wdt_osc_clk <= ~wdt_osc_clk;
      cycles <= cycles + 1;
      if ((psel & penable & pready & ~pwrite) === 1'b1)
         cmp(prdata, {24'h000000, exp_q.pop_front()});
      if (system_reset_req === 1'b1)
         pulses++;
      if (cycles == 5000)
      begin
         failures++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {wdt_osc_clk, debug_mode, boot_watchdog_setting, osc_cnt} = '0;
      {failures, check_count, cycles, pulses} = '0;
      seed = 32'h0000b680;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (40) @(posedge clock);
      rd(wcsr_pkg::ADDR_STATUS, 8'h00);
      rd(wcsr_pkg::ADDR_CONTROL, 8'h00);
      wr(wcsr_pkg::ADDR_CONTROL, 8'h01);
      rd(wcsr_pkg::ADDR_CONTROL, 8'h00);
      cmp(pulses, 32'h0);
      unl();
      wr(wcsr_pkg::ADDR_CONTROL, 8'h01);
      rd(wcsr_pkg::ADDR_STATUS, 8'h01);
      repeat (40) @(posedge clock);
      rd(wcsr_pkg::ADDR_STATUS, 8'h00);
      rd(wcsr_pkg::ADDR_CONTROL, 8'h01);
      pulse(200);
      pulse(200);
      cmp({31'h0, n > 70 && n < 90}, 32'h1);
      unl();
      wr(wcsr_pkg::ADDR_STATUS, 8'h80);
      rd(wcsr_pkg::ADDR_STATUS, 8'h80);
      seed = xs(seed);
      unl();
      wr(wcsr_pkg::ADDR_CONTROL, seed[7:0]);
      rd(wcsr_pkg::ADDR_CONTROL, 8'h01);
      repeat (30) @(posedge clock);
      unl();
      wr(wcsr_pkg::ADDR_STATUS, 8'h00);
      rd(wcsr_pkg::ADDR_STATUS, 8'h80);
      apb(1'b1, 4'h6, seed[15:8], 1'b1);
      debug_mode <= 1'b1;
      repeat (5) @(posedge clock);
      unl();
      wr(wcsr_pkg::ADDR_STATUS, 8'h00);
      rd(wcsr_pkg::ADDR_STATUS, 8'h00);
      unl();
      wr(wcsr_pkg::ADDR_CONTROL, 8'h13);
      repeat (40) @(posedge clock);
      rd(wcsr_pkg::ADDR_CONTROL, 8'h13);
      debug_mode <= 1'b0;
      repeat (10) @(posedge clock);
      // First restart opens the closed window, second lands inside it
      wr(wcsr_pkg::ADDR_COMMAND, 8'h01);
      repeat (40) @(posedge clock);
      wr(wcsr_pkg::ADDR_COMMAND, 8'h01);
      pulse(60);
      // Timely restarts in normal mode must keep the system out of reset
      unl();
      wr(wcsr_pkg::ADDR_CONTROL, 8'h02);
      repeat (40) @(posedge clock);
      base = pulses;
      repeat (4)
      begin
         wr(wcsr_pkg::ADDR_COMMAND, 8'h01);
         repeat (100) @(posedge clock);
      end
      cmp(pulses, base);
      pulse(200);
      rstn <= 1'b0;
      boot_watchdog_setting <= 8'h03;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (40) @(posedge clock);
      rd(wcsr_pkg::ADDR_CONTROL, 8'h03);
      rd(wcsr_pkg::ADDR_STATUS, 8'h80);
      print_verdict();
   end
endmodule // tb_top

/* File: testbench/wcsr_props.sv */
// Purpose: Port-level assertions for the watchdog register block
// Assumes: Zero-wait APB slave, one-clock system reset pulse
// Notes:   Bound to every wcsr_top instance
`timescale 1ns/10ps
module wcsr_props
(
   input wire logic                        clock,
   input wire logic                        rstn,
   input wire logic                        psel,
   input wire logic                        penable,
   input wire logic                        pwrite,
   input wire logic [wcsr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                 pwdata,
   input wire logic [31:0]                 prdata,
   input wire logic                        pready,
   input wire logic                        pslverr,
   input wire logic                        wdt_osc_clk,
   input wire logic                        debug_mode,
   input wire logic [7:0]                  boot_watchdog_setting,
   input wire logic                        system_reset_req,
   input wire logic                        unlock_open
);
   // ----------------------------------------
   // Bus phase decode
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   wire acc = psel & penable;
   wire key = acc & pwrite & (paddr == wcsr_pkg::ADDR_UNLOCK);

   a_ready_always: assert property (pready) else $error("pready low");
   a_err_unmapped: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   a_err_mapped: assert property (acc && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_rdata_upper: assert property (prdata[31:8] == 24'h000000) else $error("upper read bits set");
   a_status_gaps: assert property (
      acc && !pwrite && paddr == wcsr_pkg::ADDR_STATUS |-> prdata[6:1] == 6'h00)
      else $error("status reserved bits set");
   a_pulse_single: assert property (system_reset_req |=> !system_reset_req)
      else $error("reset pulse too long");
   a_unlock_opens: assert property (
      key && pwdata[7:0] == wcsr_pkg::UNLOCK_KEY |=> unlock_open)
      else $error("key did not open window");
   a_unlock_used: assert property (
      acc && pwrite && paddr == wcsr_pkg::ADDR_CONTROL |=> !unlock_open)
      else $error("window not consumed");
   a_unlock_bound: assert property ($rose(unlock_open) |-> ##[1:17] !unlock_open)
      else $error("window stayed open");
endmodule // wcsr_props

bind wcsr_top wcsr_props u_props (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .wdt_osc_clk, .debug_mode, .boot_watchdog_setting,
   .system_reset_req, .unlock_open);
